//--- logic/cctf_timer.sv
// 16-bit capture/compare timer with prescaler and filtered capture input
//
// Behaviour
// RL1: 16-bit up counter; reset clears and halts
// RL2: 3-bit prescale picks one of eight clocks
// RL3: after enable: zero on first tick, one next
// RL4: rewriting enable one does not restart counter
// RL5: clearing enable stops counter at zero
// RL6: two mode bits pick capture/compare, free/interval
// RL7: compare mode: equality raises interrupt, match remembered
// RL8: interval compare clears tick after match
// RL9: interval capture clears at valid edge
// RL10: free-running wraps after all ones
// RL11: capture mode: cc register latches counter on edge
// RL12: capture-only register latches counter on each edge
// RL13: writes hit compare storage; reads follow mode
// RL14: control bits 6 and 5 read zero
// RL15: software keeps mode/prescale fixed while enabled
// RL16: compare mode: capture input gives no interrupt
// RL17: compare and capture interrupts share one request
// RL18: edge register selects edge; bits 7-4 zero
// RL19: sampling register selects filter clocks; resets zero
// RL20: filter takes level after four agreeing samples
// RL21: pulses of three samples rejected, four pass
// RL22: edges are taken from the filtered synchronous input
`timescale 1ns/1ps

module cctf_timer
(
	// clock and reset
	input  logic        MCLK,
	input  logic        RST,
	// register port
	input  logic [15:0] ADDR,
	input  logic        WR,
	input  logic        RD,
	input  logic [15:0] WDATA,
	output logic [15:0] RDATA,
	// external inputs
	input  logic        EXT_CAPTURE_IN,
	input  logic        EXT_IN_A,
	input  logic        EXT_IN_B,
	// interrupt and filtered levels
	output logic        IRQ_CC,
	output logic        FILT_A,
	output logic        FILT_B
);

	// ==========================================================
	// decode helpers
	function automatic logic tick_at(input logic [cctf_pkg::PRE_W-1:0] pre,
		input logic [3:0] exp);
		logic [cctf_pkg::PRE_W-1:0] mask;
		mask    = (cctf_pkg::PRE_W)'((11'h001 << exp) - 11'h001);
		tick_at = ((pre & mask) == mask);
	endfunction

	function automatic logic [3:0] prm_exp(input logic [2:0] sel);
		unique case (sel)
			3'h0: prm_exp = cctf_pkg::PRM_EXP0;
			3'h1: prm_exp = cctf_pkg::PRM_EXP1;
			3'h2: prm_exp = cctf_pkg::PRM_EXP2;
			3'h3: prm_exp = cctf_pkg::PRM_EXP3;
			3'h4: prm_exp = cctf_pkg::PRM_EXP4;
			3'h5: prm_exp = cctf_pkg::PRM_EXP5;
			3'h6: prm_exp = cctf_pkg::PRM_EXP6;
			3'h7: prm_exp = cctf_pkg::PRM_EXP7;
		endcase
	endfunction

	function automatic logic [3:0] smp_exp(input logic [1:0] sel);
		unique case (sel)
			2'h0: smp_exp = cctf_pkg::SMP_EXP0;
			2'h1: smp_exp = cctf_pkg::SMP_EXP1;
			2'h2: smp_exp = cctf_pkg::SMP_EXP2;
			2'h3: smp_exp = cctf_pkg::SMP_EXP3;
		endcase
	endfunction

	// ==========================================================
	// state
	logic [cctf_pkg::PRE_W-1:0] pre_q,   pre_d;
	logic [7:0]                 ctl_q,   ctl_d;
	logic [7:0]                 edge_q,  edge_d;
	logic [7:0]                 smpc_q,  smpc_d;
	logic [15:0]                cnt_q,   cnt_d;
	logic [15:0]                cmp_q,   cmp_d;
	logic [15:0]                ccap_q,  ccap_d;
	logic [15:0]                ct_q,    ct_d;
	logic                       first_q, first_d;
	logic                       pend_q,  pend_d;
	logic                       mprev_q, mprev_d;
	logic                       lprev_q, lprev_d;
	logic                       irq_d;
	logic [15:0]                rdata_d;
	logic [cctf_pkg::NUM_INPUTS-1:0] sync1_q, sync2_q, lvl;

	logic ce, cc_mode, clr_mode, cnt_tick, match_now, match_rise, cap_edge;
	logic wr_ctl, new_ce;

	assign ce       = ctl_q[cctf_pkg::CTL_CE_BIT];
	assign cc_mode  = ctl_q[cctf_pkg::CTL_CCM_BIT];             // [RL6]
	assign clr_mode = ctl_q[cctf_pkg::CTL_CLR_BIT];
	assign wr_ctl   = WR && (ADDR == cctf_pkg::OFS_CTL);
	assign new_ce   = WDATA[cctf_pkg::CTL_CE_BIT];
	// one count tick per selected divided clock [RL2]
	assign cnt_tick = tick_at(pre_q, prm_exp(ctl_q[cctf_pkg::CTL_PRM_LSB +: 3]));

	// ==========================================================
	// input synchronisers and filters
	logic [cctf_pkg::NUM_INPUTS-1:0] raw_in;
	assign raw_in = {EXT_IN_B, EXT_IN_A, EXT_CAPTURE_IN};

	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
		end
		else
		begin
			sync1_q <= raw_in;
			sync2_q <= sync1_q;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < cctf_pkg::NUM_INPUTS; gi++)
		begin : g_filt
			logic smp_en;
			// each input has its own sampling clock select [RL19]
			assign smp_en = tick_at(pre_q, smp_exp(smpc_q[2*gi +: 2]));
			cctf_filter u_filt
			(
				.clk       (MCLK),
				.rst       (RST),
				.sample_en (smp_en),
				.din       (sync2_q[gi]),
				.level_q   (lvl[gi])
			);
		end
	endgenerate

	assign FILT_A = lvl[1];
	assign FILT_B = lvl[2];

	// ==========================================================
	// edge and match detection
	always_comb
	begin
		// edges come from the filtered level only [RL22] [RL18]
		unique case (edge_q[1:0])
			cctf_pkg::EDGE_FALL: cap_edge = lprev_q & ~lvl[0];
			cctf_pkg::EDGE_RISE: cap_edge = ~lprev_q & lvl[0];
			cctf_pkg::EDGE_NONE: cap_edge = 1'b0;
			cctf_pkg::EDGE_BOTH: cap_edge = lprev_q ^ lvl[0];
		endcase
		// compare runs continuously while counting [RL7]
		match_now  = ce && cc_mode && (cnt_q == cmp_q);
		match_rise = match_now && !mprev_q;
	end

	// ==========================================================
	// counter and register next state
	always_comb
	begin
		pre_d   = pre_q + 1'b1;
		ctl_d   = ctl_q;
		edge_d  = edge_q;
		smpc_d  = smpc_q;
		cmp_d   = cmp_q;
		cnt_d   = cnt_q;
		first_d = first_q;
		// the match is held until the tick that consumes it [RL7]
		pend_d  = (pend_q && !cnt_tick) || match_rise;
		mprev_d = match_now;
		lprev_d = lvl[0];
		ccap_d  = ccap_q;
		ct_d    = ct_q;
		// one shared request for match and capture edge [RL17] [RL16]
		irq_d   = match_rise || (cap_edge && !cc_mode);
		rdata_d = RDATA;

		if (cap_edge)
		begin
			ct_d = cnt_q;                                   // [RL12]
			if (!cc_mode)
				ccap_d = cnt_q;                             // [RL11]
		end

		if (WR)
		begin
			unique case (ADDR)
				cctf_pkg::OFS_CTL:    ctl_d  = WDATA[7:0] & cctf_pkg::CTL_WMASK;  // [RL14]
				cctf_pkg::OFS_EDGE:   edge_d = WDATA[7:0] & cctf_pkg::EDGE_WMASK; // [RL18]
				cctf_pkg::OFS_SAMPLE: smpc_d = WDATA[7:0];
				cctf_pkg::OFS_CAPCMP: cmp_d  = WDATA;       // [RL13]
				default:              ;
			endcase
		end

		if (wr_ctl && !new_ce)
		begin
			cnt_d   = cctf_pkg::CNT_RESET;                  // [RL5]
			first_d = 1'b0;
			pend_d  = 1'b0;
		end
		else if (wr_ctl && new_ce && !ce)
		begin
			// start: the first tick only arms the count [RL3]
			cnt_d   = cctf_pkg::CNT_RESET;
			first_d = 1'b1;
			pend_d  = 1'b0;
		end
		else if (ce)
		begin
			// a repeated enable write lands here untouched [RL4]
			if (!cc_mode && clr_mode && cap_edge)
			begin
				cnt_d   = cctf_pkg::CNT_RESET;              // [RL9]
				first_d = 1'b0;
			end
			else if (cnt_tick)
			begin
				if (first_q)
					first_d = 1'b0;                         // [RL3]
				else if (cc_mode && clr_mode && pend_q)
					cnt_d = cctf_pkg::CNT_RESET;            // [RL8]
				else
					cnt_d = cnt_q + 1'b1;                   // [RL1] [RL10]
			end
		end

		if (RD)
		begin
			unique case (ADDR)
				cctf_pkg::OFS_CTL:     rdata_d = {8'h00, ctl_q};
				cctf_pkg::OFS_EDGE:    rdata_d = {8'h00, edge_q};
				cctf_pkg::OFS_SAMPLE:  rdata_d = {8'h00, smpc_q};
				cctf_pkg::OFS_COUNTER: rdata_d = cnt_q;
				cctf_pkg::OFS_CAPCMP:  rdata_d = cc_mode ? cmp_q : ccap_q; // [RL13]
				cctf_pkg::OFS_CAPONLY: rdata_d = ct_q;
				default:               rdata_d = 16'h0000;
			endcase
		end
	end

	// mode and prescale are assumed steady while counting [RL15] [RL6]
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			pre_q   <= '0;
			ctl_q   <= cctf_pkg::CTL_RESET;                 // [RL1]
			edge_q  <= cctf_pkg::EDGE_RESET;
			smpc_q  <= cctf_pkg::SAMPLE_RESET;              // [RL19]
			cnt_q   <= cctf_pkg::CNT_RESET;                 // [RL1]
			cmp_q   <= 16'h0000;
			ccap_q  <= 16'h0000;
			ct_q    <= 16'h0000;
			first_q <= 1'b0;
			pend_q  <= 1'b0;
			mprev_q <= 1'b0;
			lprev_q <= 1'b0;
			IRQ_CC  <= 1'b0;
			RDATA   <= 16'h0000;
		end
		else
		begin
			pre_q   <= pre_d;
			ctl_q   <= ctl_d;
			edge_q  <= edge_d;
			smpc_q  <= smpc_d;
			cnt_q   <= cnt_d;
			cmp_q   <= cmp_d;
			ccap_q  <= ccap_d;
			ct_q    <= ct_d;
			first_q <= first_d;
			pend_q  <= pend_d;
			mprev_q <= mprev_d;
			lprev_q <= lprev_d;
			IRQ_CC  <= irq_d;
			RDATA   <= rdata_d;
		end
	end

	// ==========================================================
	// checks
	a_reset_clears: assert property (@(posedge MCLK) // [RL1]
		RST |=> (cnt_q == 16'h0000) && !ce)
		else $error("reset did not clear and halt the counter");

	a_stop_holds_zero: assert property (@(posedge MCLK) disable iff (RST) // [RL5]
		!ce |-> (cnt_q == 16'h0000))
		else $error("counter not zero while disabled");

	a_first_tick: assert property (@(posedge MCLK) disable iff (RST) // [RL3]
		(ce && first_q && cnt_tick && !wr_ctl && !cap_edge) |=> (cnt_q == 16'h0000) && !first_q)
		else $error("first count tick after enable moved the counter");

	a_free_step: assert property (@(posedge MCLK) disable iff (RST) // [RL10]
		(ce && !clr_mode && cnt_tick && !first_q && !wr_ctl)
		|=> (cnt_q == $past(cnt_q) + 16'h0001))
		else $error("free-running counter did not step or wrap");

	a_hold_no_tick: assert property (@(posedge MCLK) disable iff (RST) // [RL2]
		(!cnt_tick && !cap_edge && !wr_ctl) |=> $stable(cnt_q))
		else $error("counter moved without a count tick");

	a_restart_none: assert property (@(posedge MCLK) disable iff (RST) // [RL4]
		(ce && wr_ctl && new_ce && !cnt_tick && !cap_edge) |=> $stable(cnt_q) && ce)
		else $error("repeated enable write disturbed the counter");

	a_int_clear: assert property (@(posedge MCLK) disable iff (RST) // [RL8]
		(ce && cc_mode && clr_mode && pend_q && cnt_tick && !first_q && !wr_ctl)
		|=> (cnt_q == 16'h0000))
		else $error("interval compare did not clear after match");

	a_cap_clear: assert property (@(posedge MCLK) disable iff (RST) // [RL9]
		(ce && !cc_mode && clr_mode && cap_edge && !wr_ctl) |=> (cnt_q == 16'h0000))
		else $error("interval capture did not clear on edge");

	a_cc_capture: assert property (@(posedge MCLK) disable iff (RST) // [RL11]
		(cap_edge && !cc_mode) |=> (ccap_q == $past(cnt_q)) && (ct_q == $past(cnt_q)))
		else $error("capture registers missed the counter value");

	a_match_irq: assert property (@(posedge MCLK) disable iff (RST) // [RL7]
		(match_rise && !wr_ctl) |=> IRQ_CC && pend_q)
		else $error("compare match gave no request");

	a_no_ext_irq: assert property (@(posedge MCLK) disable iff (RST) // [RL16]
		(cc_mode && !match_rise) |=> !IRQ_CC)
		else $error("capture input raised a request in compare mode");

	a_fixed_zero: assert property (@(posedge MCLK) disable iff (RST) // [RL14]
		(ctl_q[6:5] == 2'h0) && (edge_q[7:4] == 4'h0))
		else $error("fixed-zero control bits set");

endmodule

//--- logic/cctf_pkg.sv
// constants shared by the capture/compare timer and its input filter
package cctf_pkg;

	// ==========================================================
	// register map (byte addresses on the register port)
	localparam logic [15:0] OFS_CTL      = 16'hff7e;
	localparam logic [15:0] OFS_COUNTER  = 16'hff70;
	localparam logic [15:0] OFS_CAPCMP   = 16'hff72;
	localparam logic [15:0] OFS_CAPONLY  = 16'hff74;
	localparam logic [15:0] OFS_EDGE     = 16'hff76;
	localparam logic [15:0] OFS_SAMPLE   = 16'hff78;

	// ==========================================================
	// control register fields
	localparam int          CTL_CE_BIT   = 7;
	localparam int          CTL_CCM_BIT  = 4;
	localparam int          CTL_CLR_BIT  = 3;
	localparam int          CTL_PRM_LSB  = 0;
	localparam logic [7:0]  CTL_WMASK    = 8'h9f;
	localparam logic [7:0]  EDGE_WMASK   = 8'h0f;

	// ==========================================================
	// reset values
	localparam logic [7:0]  CTL_RESET    = 8'h00;
	localparam logic [7:0]  EDGE_RESET   = 8'h00;
	localparam logic [7:0]  SAMPLE_RESET = 8'h00;
	localparam logic [15:0] CNT_RESET    = 16'h0000;

	// ==========================================================
	// divider exponents: count clock (PRM) or sample clock (SMP) is fclk / 2**exp
	localparam logic [3:0]  PRM_EXP0 = 4'h2;
	localparam logic [3:0]  PRM_EXP1 = 4'h3;
	localparam logic [3:0]  PRM_EXP2 = 4'h4;
	localparam logic [3:0]  PRM_EXP3 = 4'h5;
	localparam logic [3:0]  PRM_EXP4 = 4'h6;
	localparam logic [3:0]  PRM_EXP5 = 4'h8;
	localparam logic [3:0]  PRM_EXP6 = 4'h9;
	localparam logic [3:0]  PRM_EXP7 = 4'ha;
	localparam logic [3:0]  SMP_EXP0 = 4'h1;
	localparam logic [3:0]  SMP_EXP1 = 4'h2;
	localparam logic [3:0]  SMP_EXP2 = 4'h3;
	localparam logic [3:0]  SMP_EXP3 = 4'h4;
	localparam int          PRE_W    = 10;

	// ==========================================================
	// edge select codes and filter depth
	localparam logic [1:0]  EDGE_FALL = 2'h0;
	localparam logic [1:0]  EDGE_RISE = 2'h1;
	localparam logic [1:0]  EDGE_NONE = 2'h2;
	localparam logic [1:0]  EDGE_BOTH = 2'h3;
	localparam int          FILT_PTS  = 4;
	localparam int          NUM_INPUTS = 3;

endpackage

//--- logic/cctf_filter.sv
// four-point sampling noise filter for one synchronised input
`timescale 1ns/1ps

module cctf_filter
(
	// clock and reset
	input  logic clk,
	input  logic rst,
	// sample strobe and synchronised input
	input  logic sample_en,
	input  logic din,
	// accepted level
	output logic level_q
);

	logic [cctf_pkg::FILT_PTS-1:0] smp_q;
	logic [cctf_pkg::FILT_PTS-1:0] smp_d;
	logic                          level_d;

	// ==========================================================
	// sample shift and agreement
	always_comb
	begin
		smp_d   = smp_q;
		level_d = level_q;
		if (sample_en)
		begin
			smp_d = {smp_q[cctf_pkg::FILT_PTS-2:0], din};
			// a level is taken only when four samples agree [RL20] [RL21]
			if (&smp_d)
				level_d = 1'b1;
			else if (~|smp_d)
				level_d = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			smp_q   <= '0;
			level_q <= 1'b0;
		end
		else
		begin
			smp_q   <= smp_d;
			level_q <= level_d;
		end
	end

	// ==========================================================
	// checks
	a_level_agree: assert property (@(posedge clk) disable iff (rst) // [RL20]
		$changed(level_q) |-> (smp_q == {cctf_pkg::FILT_PTS{level_q}}))
		else $error("filter level changed without four agreeing samples");

endmodule

//--- testbench/cctf_src.sv
// external signal source model driving the capture input pin
`timescale 1ns/1ps

module cctf_src
(
	// clock
	input  logic clk,
	// pin level
	output logic pin
);
	initial pin = 1'b0;

	// ==========
	// one high pulse, then low for the same width; callers pick the
	// width; the 10-cycle pulse is passed at the default sampling and rejected at the slower one
	task automatic pulse(input int width);
		@(posedge clk);
		#1 pin = 1'b1;
		repeat (width) @(posedge clk);
		#1 pin = 1'b0;
		repeat (width) @(posedge clk);
	endtask
endmodule

//--- testbench/tb.sv
// self-checking bench for the capture/compare timer
`timescale 1ns/1ps

module tb;
	// ==========
	// signals
	logic        MCLK;
	logic        RST;
	logic [15:0] ADDR;
	logic        WR;
	logic        RD;
	logic [15:0] WDATA;
	logic [15:0] RDATA;
	logic        EXT_CAPTURE_IN;
	logic        EXT_IN_A;
	logic        EXT_IN_B;
	logic        IRQ_CC;
	logic        FILT_A;
	logic        FILT_B;
	int          miscompares;
	int          total_checks;
	int          irq_n = 0;

	// divider exponents of the eight prescale codes, code 0 lowest
	localparam logic [31:0] PRM_EXPS = {cctf_pkg::PRM_EXP7, cctf_pkg::PRM_EXP6,
		cctf_pkg::PRM_EXP5, cctf_pkg::PRM_EXP4, cctf_pkg::PRM_EXP3,
		cctf_pkg::PRM_EXP2, cctf_pkg::PRM_EXP1, cctf_pkg::PRM_EXP0};

	cctf_timer i_dut
	(
		.MCLK(MCLK),
		.RST(RST),
		.ADDR(ADDR),
		.WR(WR),
		.RD(RD),
		.WDATA(WDATA),
		.RDATA(RDATA),
		.EXT_CAPTURE_IN(EXT_CAPTURE_IN),
		.EXT_IN_A(EXT_IN_A),
		.EXT_IN_B(EXT_IN_B),
		.IRQ_CC(IRQ_CC),
		.FILT_A(FILT_A),
		.FILT_B(FILT_B)
	);

	cctf_src i_src
	(
		.clk(MCLK),
		.pin(EXT_CAPTURE_IN)
	);

	always #50 MCLK = ~MCLK;

	// counting pulses catches both missing and stretched requests
	always @(posedge MCLK)
		if (IRQ_CC === 1'b1)
			irq_n <= irq_n + 1;

	// ==========
	// shared tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_sim;
		if (miscompares == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge MCLK);
		#1 ADDR = a;
		WDATA = d;
		WR = 1'b1;
		@(posedge MCLK);
		#1 WR = 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge MCLK);
		#1 ADDR = a;
		RD = 1'b1;
		@(posedge MCLK);
		#1 RD = 1'b0;
		@(posedge MCLK);
		#1 d = RDATA;
	endtask

	task automatic irq_chk(input int n0, input logic [15:0] exp);
		#1 chk(16'(irq_n - n0), exp);
	endtask

	// ==========
	// scenarios
	task automatic t_regs;
		logic [15:0] rv;
		rd(cctf_pkg::OFS_COUNTER, rv);
		chk(rv, 16'h0000);
		rd(cctf_pkg::OFS_SAMPLE, rv);
		chk(rv, 16'h0000);
		rd(16'hff7c, rv);
		chk(rv, 16'h0000);
		wr(cctf_pkg::OFS_CTL, 16'h0067);
		rd(cctf_pkg::OFS_CTL, rv);
		chk(rv, 16'h0007);
		wr(cctf_pkg::OFS_EDGE, 16'h00ff);
		rd(cctf_pkg::OFS_EDGE, rv);
		chk(rv, 16'h000f);
		wr(cctf_pkg::OFS_CTL, 16'h0000);
	endtask

	task automatic t_enable;
		logic [15:0] rv;
		logic [15:0] rv2;
		int          i;
		wr(cctf_pkg::OFS_CTL, 16'h0080);
		rv = 16'h0000;
		for (i = 0; i < 20 && rv === 16'h0000; i++)
			rd(cctf_pkg::OFS_COUNTER, rv);
		chk(rv, 16'h0001);
		if (rv === 16'h0000)
			end_sim;
		repeat (40) @(posedge MCLK);
		rd(cctf_pkg::OFS_COUNTER, rv);
		wr(cctf_pkg::OFS_CTL, 16'h0080);
		rd(cctf_pkg::OFS_COUNTER, rv2);
		chk({15'h0000, rv2 > rv}, 16'h0001);
		wr(cctf_pkg::OFS_CTL, 16'h0000);
		repeat (20) @(posedge MCLK);
		rd(cctf_pkg::OFS_COUNTER, rv);
		chk(rv, 16'h0000);
		// prescale only changes while stopped
		// eight periods of every divided clock; the first tick only arms
		for (i = 0; i < 8; i++)
		begin
			wr(cctf_pkg::OFS_CTL, 16'h0080 | 16'(i));
			repeat (8 << PRM_EXPS[4*i +: 4]) @(posedge MCLK);
			rd(cctf_pkg::OFS_COUNTER, rv);
			chk({15'h0000, rv >= 16'h0007 && rv <= 16'h0008}, 16'h0001);
			wr(cctf_pkg::OFS_CTL, 16'h0000);
		end
	endtask

	task automatic t_cmp;
		logic [15:0] rv;
		logic [15:0] top;
		int          n0;
		int          i;
		wr(cctf_pkg::OFS_CAPCMP, 16'h0005);
		wr(cctf_pkg::OFS_CTL, 16'h0098);
		rd(cctf_pkg::OFS_CAPCMP, rv);
		chk(rv, 16'h0005);
		top = 16'h0000;
		for (i = 0; i < 40; i++)
		begin
			rd(cctf_pkg::OFS_COUNTER, rv);
			if (rv > top)
				top = rv;
		end
		chk(top, 16'h0005);
		n0 = irq_n;
		repeat (240) @(posedge MCLK);
		irq_chk(n0, 16'h000a);
		wr(cctf_pkg::OFS_CTL, 16'h0000);
	endtask

	task automatic t_cap;
		logic [15:0] cc;
		logic [15:0] co;
		logic [15:0] cnt;
		int          c;
		int          n0;
		wr(cctf_pkg::OFS_CTL, 16'h0088);
		for (c = 0; c < 4; c++)
		begin
			wr(cctf_pkg::OFS_EDGE, 16'(c));
			n0 = irq_n;
			i_src.pulse(20);
			repeat (20) @(posedge MCLK);
			irq_chk(n0, (c == 2) ? 16'h0000 : (c == 3) ? 16'h0002 : 16'h0001);
		end
		wr(cctf_pkg::OFS_EDGE, 16'h0001);
		repeat (100) @(posedge MCLK);
		i_src.pulse(20);
		rd(cctf_pkg::OFS_CAPCMP, cc);
		rd(cctf_pkg::OFS_CAPONLY, co);
		rd(cctf_pkg::OFS_COUNTER, cnt);
		chk(co, cc);
		chk({15'h0000, cc > 16'h0010}, 16'h0001);
		chk({15'h0000, cnt < cc}, 16'h0001);
		wr(cctf_pkg::OFS_CAPCMP, 16'h1234);
		rd(cctf_pkg::OFS_CAPCMP, co);
		chk(co, cc);
	endtask

	task automatic t_noise;
		int          n0;
		logic [15:0] rv;
		n0 = irq_n;
		EXT_IN_A = 1'b1;
		i_src.pulse(6);
		repeat (20) @(posedge MCLK);
		irq_chk(n0, 16'h0000);
		chk({15'h0000, FILT_A}, 16'h0001);
		chk({15'h0000, FILT_B}, 16'h0000);
		EXT_IN_A = 1'b0;
		n0 = irq_n;
		i_src.pulse(10);
		repeat (20) @(posedge MCLK);
		irq_chk(n0, 16'h0001);
		// slower sampling: ten cycles hold under four samples
		wr(cctf_pkg::OFS_SAMPLE, 16'h0001);
		rd(cctf_pkg::OFS_SAMPLE, rv);
		chk(rv, 16'h0001);
		n0 = irq_n;
		i_src.pulse(10);
		repeat (20) @(posedge MCLK);
		irq_chk(n0, 16'h0000);
		n0 = irq_n;
		i_src.pulse(20);
		repeat (20) @(posedge MCLK);
		irq_chk(n0, 16'h0001);
		wr(cctf_pkg::OFS_CTL, 16'h0000);
	endtask

	task automatic t_cmp_pin;
		int          n0;
		logic [15:0] rv;
		wr(cctf_pkg::OFS_CAPCMP, 16'hffff);
		wr(cctf_pkg::OFS_CTL, 16'h0090);
		n0 = irq_n;
		i_src.pulse(20);
		irq_chk(n0, 16'h0000);
		// reset in mid-run must stop and clear the counter
		RST = 1'b1;
		repeat (3) @(posedge MCLK);
		#1 RST = 1'b0;
		rd(cctf_pkg::OFS_COUNTER, rv);
		chk(rv, 16'h0000);
		rd(cctf_pkg::OFS_CTL, rv);
		chk(rv, 16'h0000);
		rd(cctf_pkg::OFS_SAMPLE, rv);
		chk(rv, 16'h0000);
	endtask

	// ==========
	// main sequence
	initial
	begin
		MCLK = 1'b0;
		RST = 1'b1;
		ADDR = 16'h0000;
		WR = 1'b0;
		RD = 1'b0;
		WDATA = 16'h0000;
		EXT_IN_A = 1'b0;
		EXT_IN_B = 1'b0;
		miscompares = 0;
		total_checks = 0;
		repeat (3) @(posedge MCLK);
		#1 RST = 1'b0;
		t_regs;
		t_enable;
		t_cmp;
		t_cap;
		t_noise;
		t_cmp_pin;
		end_sim;
	end
endmodule
